/* File: divider_pkg.sv */
`default_nettype none

package divider_pkg;

	// ----------------------------------------------------------------
	// Division code and counter constants
	// ----------------------------------------------------------------
	localparam int CODE_WIDTH = 5;                      // Code bit count
	localparam logic [4:0] CODE_OFF   = 5'h00;          // Code that holds output low
	localparam logic [4:0] COUNT_ZERO = 5'h00;          // Terminal count
	localparam logic [4:0] COUNT_ONE  = 5'h01;          // Decrement step
	localparam logic [4:0] COUNT_RST  = 5'h00;          // Counter value after reset
	localparam int SETTLE_ASYNC_MAX = 32;               // Worst case cycles after a torn load

endpackage

`default_nettype wire

/* File: code_sampler.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Load-point register for the division code
// ----------------------------------------------------------------
module code_sampler #(
	parameter int WIDTH = 5
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             sys_rst,
	// Code path
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] code_in,
	output var  logic [WIDTH-1:0] code_q
);

	// Captured only at load points, so the code is a static level input
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			code_q <= '0;
		end else if (load) begin
			code_q <= code_in;
		end
	end

endmodule
`default_nettype wire

/* File: prog_divider.sv */
`timescale 1ns/1ps
`default_nettype none

module prog_divider #(
	parameter int CODE_W = divider_pkg::CODE_WIDTH
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              sys_rst,
	// Division code, level input
	input  wire logic [CODE_W-1:0] division_code_bits,
	// Divider outputs
	output var  logic              divider_out,
	output var  logic              divider_test_output_complement
);

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (CODE_W != divider_pkg::CODE_WIDTH) begin : g_bad_width
		$error("prog_divider supports a five bit code only");
	end

	// Period counter width: one bit above the code so a ratio of 32 fits
	localparam int GAP_W = CODE_W + 1;

	// ----------------------------------------------------------------
	// Counter state and decode
	// ----------------------------------------------------------------
	logic [CODE_W-1:0] count_r;      // Remaining counts in this cycle
	logic [CODE_W-1:0] count_nxt;
	logic [CODE_W-1:0] code_q;       // Code captured at the last load
	logic              pulse_load;   // Load at the end of a pulse
	logic              idle_load;    // Load while parked on a zero code
	logic              load_point;
	logic              pulse_nxt;
	logic [GAP_W-1:0]  gap_r;        // Cycles since the last load

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Terminal count, the only place a cycle may reload
	function automatic logic at_terminal(input logic [CODE_W-1:0] count);
		at_terminal = (count == divider_pkg::COUNT_ZERO);
	endfunction

	// One count before terminal, where the pulse is launched
	function automatic logic at_last_step(input logic [CODE_W-1:0] count);
		at_last_step = (count == divider_pkg::COUNT_ONE);
	endfunction

	// Zero code parks the divider with its output low
	function automatic logic code_is_off(input logic [CODE_W-1:0] code);
		code_is_off = (code == divider_pkg::CODE_OFF);
	endfunction

	// Cycle length for a code, one bit wider so ratio 32 fits
	function automatic logic [GAP_W-1:0] ratio_of(input logic [CODE_W-1:0] code);
		ratio_of = {1'b0, code} + {1'b0, divider_pkg::COUNT_ONE};
	endfunction

	// ----------------------------------------------------------------
	// Load point decode
	// ----------------------------------------------------------------
	// load while high
	// no load strobe
	// A parked divider keeps loading, so a nonzero code restarts it
	// without a reset; reset needs no special start-up path either
	always_comb begin
		pulse_load = divider_out;
		idle_load  = code_is_off(code_q) && at_terminal(count_r) && !divider_out;
		load_point = pulse_load || idle_load;
	end

	// ----------------------------------------------------------------
	// Load register
	// ----------------------------------------------------------------
	// reload every cycle
	// A torn capture only lives until the next terminal count, at most
	// one full cycle of 32 clocks, because every cycle reloads
	code_sampler #(
		.WIDTH   (CODE_W)
	) u_sampler (
		.clock   (clock),
		.sys_rst (sys_rst),
		.load    (load_point),
		.code_in (division_code_bits),
		.code_q  (code_q)
	);

	// ----------------------------------------------------------------
	// Down counter
	// ----------------------------------------------------------------
	// count down to zero
	// bit 0 weighs one
	// The counter loads straight from the pins, not from code_q, so the
	// new code counts from the very cycle it is taken
	always_comb begin
		if (load_point) begin
			count_nxt = division_code_bits;
		end else begin
			count_nxt = count_r - divider_pkg::COUNT_ONE;
		end
	end

	// Count register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			count_r <= divider_pkg::COUNT_RST;
		end else begin
			count_r <= count_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Output pulse
	// ----------------------------------------------------------------
	// zero code never pulses
	// new ratio from load
	// Launched one count early so the registered pulse lines up with
	// terminal count; a load cycle never pulses, which keeps ratio 2 at
	// one high and one low cycle
	always_comb begin
		pulse_nxt = !load_point && at_last_step(count_r);
	end

	// Divider output register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			divider_out <= 1'b0;
		end else begin
			divider_out <= pulse_nxt;
		end
	end

	// Complement output register, its own flop so both edges line up
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			divider_test_output_complement <= 1'b1;
		end else begin
			divider_test_output_complement <= !pulse_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Helper for the period checks, saturates instead of wrapping
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			gap_r <= '0;
		end else if (load_point) begin
			gap_r <= GAP_W'(divider_pkg::COUNT_ONE);
		end else if (gap_r != '1) begin
			gap_r <= gap_r + GAP_W'(divider_pkg::COUNT_ONE);
		end
	end

	// Nonzero code taken at a load point
	sequence s_nonzero_load;
		load_point && !code_is_off(division_code_bits);
	endsequence

	// First two counts after that load: the code, then one less
	sequence s_first_counts;
		(count_r == code_q && !divider_out) ##1 (count_r == code_q - divider_pkg::COUNT_ONE);
	endsequence

	chk_off_low: assert property (@(posedge clock) disable iff (sys_rst)
		code_is_off(code_q) |-> !divider_out)
		else $error("zero code must hold output low");

	chk_capture_high: assert property (@(posedge clock) disable iff (sys_rst)
		divider_out |=> (code_q == $past(division_code_bits)))
		else $error("code not captured while output high");

	chk_hold_low: assert property (@(posedge clock) disable iff (sys_rst)
		!load_point |=> (code_q == $past(code_q)))
		else $error("code changed outside load point");

	chk_load_terminal: assert property (@(posedge clock) disable iff (sys_rst)
		load_point |-> at_terminal(count_r))
		else $error("load outside terminal count");

	chk_complement: assert property (@(posedge clock) disable iff (sys_rst)
		divider_test_output_complement == !divider_out)
		else $error("complement output mismatch");

	chk_pulse_width: assert property (@(posedge clock) disable iff (sys_rst)
		divider_out |=> !divider_out)
		else $error("pulse longer than one cycle");

	chk_period_max: assert property (@(posedge clock) disable iff (sys_rst)
		gap_r <= GAP_W'(divider_pkg::SETTLE_ASYNC_MAX))
		else $error("count cycle longer than 32 clocks");

	chk_ratio_exact: assert property (@(posedge clock) disable iff (sys_rst)
		divider_out |-> (gap_r == ratio_of(code_q)))
		else $error("pulse spacing differs from code plus one");

	chk_count_start: assert property (@(posedge clock) disable iff (sys_rst)
		s_nonzero_load |=> s_first_counts)
		else $error("count does not start from the loaded code");

endmodule
`default_nettype wire

/* File: code_driver_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Control logic that drives the division code
// ----------------------------------------------------------------
module code_driver_model (
	// Clock
	input  wire logic       clock,
	// Request from the bench
	input  wire logic [4:0] want_code,
	input  wire logic       sync_mode,
	// Divider side
	input  wire logic       divider_test_output_complement,
	output var  logic [4:0] division_code_bits
);
	logic prev_comp;

	// One process owns the code bits; changes land 2 ns after the edge,
	// clear of the bench's own 1 ns stimulus step
	initial begin
		division_code_bits = 5'h00;
		prev_comp          = 1'b1;
		forever begin
			@(posedge clock);
			#2;
			// update after complement rise
			// Free mode changes the bits in any cycle, load cycles included
			if (!sync_mode || (divider_test_output_complement && !prev_comp)) begin
				division_code_bits = want_code;
			end
			prev_comp = divider_test_output_complement;
		end
	end
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Divider bench
// ----------------------------------------------------------------
module tb;
	logic       clock;
	logic       sys_rst;
	logic [4:0] want_code;
	logic       sync_mode;
	logic [4:0] code_bits;
	logic       div_out;
	logic       div_out_n;
	logic [5:0] exp_q[$];
	logic [4:0] codes [8];
	int         fails;
	int         cmp_count;
	int         gap;
	int         pulses;
	int         seed;

	// Clock at 100 MHz
	always #5 clock = ~clock;

	prog_divider i_dut (.clock(clock), .sys_rst(sys_rst), .division_code_bits(code_bits),
		.divider_out(div_out), .divider_test_output_complement(div_out_n));
	code_driver_model i_ctrl (.clock(clock), .want_code(want_code), .sync_mode(sync_mode),
		.divider_test_output_complement(div_out_n), .division_code_bits(code_bits));

	task automatic check(input logic [5:0] seen, input logic [5:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Pulse spacing against the oldest note, sampled mid-cycle where settled
	always @(negedge clock) begin
		gap++;
		if (!sys_rst) check(6'(div_out_n), 6'(!div_out));
		if (!sys_rst && div_out === 1'b1) begin
			pulses++;
			if (exp_q.size() > 0) check(6'(gap), exp_q.pop_front());
			gap = 0;
		end
	end

	// Codes with asymmetric bits, bounds and random picks; zero last, a parked divider gives no complement edge
	initial begin
		clock = 1'b0;
		sys_rst = 1'b1;
		want_code = 5'h00;
		sync_mode = 1'b1;
		seed = 32'h93572dab;
		codes = '{5'h01, 5'h02, 5'h10, 5'h1F, 5'h03, 5'h08, 5'h04, 5'h00};
		repeat (20) @(posedge clock);
		#1 sys_rst = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (i inside {4, 5}) codes[i] = 5'({$random(seed)} % 31 + 1);
			want_code = codes[i];
			sync_mode = i[0];
			repeat (70) @(posedge clock);
			#1 pulses = 0;
			if (codes[i] != 5'h00) begin
				exp_q.push_back(6'(codes[i]) + 6'h01);
				exp_q.push_back(6'(codes[i]) + 6'h01);
				repeat (70) @(posedge clock);
				#1 check(6'(exp_q.size()), 6'h00);
				exp_q.delete();
			end else begin
				repeat (64) @(posedge clock);
				#1 check(6'(pulses), 6'h00);
			end
		end
		print_verdict();
	end

	// Watchdog
	initial begin
		#100000;
		fails++;
		print_verdict();
	end
endmodule
`default_nettype wire
